// >>> hdl/fbpll_select.sv
`timescale 1ns/1ns
module fbpll_select
   import fbpll_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [fbpll_pkg::BOOT_W-1:0] boot_source_strap,
   input wire logic host_bus_enable_strap,
   input wire logic [fbpll_pkg::EBM_W-1:0] ext_bus_mode_strap,
   input wire logic [fbpll_pkg::MS_W-1:0] multiplier_select_strap,
   input wire logic fast_start_strap,
   output logic [fbpll_pkg::BOOT_W-1:0] boot_config_latch,
   output logic [fbpll_pkg::PLL_MULTIPLIER_FIELD_W-1:0] pll_multiplier_field,
   output logic [fbpll_pkg::DIV_W-1:0] core_clock_divider,
   output logic pll_bypass,
   output logic pll_program,
   output logic cache_disable,
   output logic emulation_idle,
   output logic boot_continue,
   output logic [4:0] eeprom_addr_bits,
   output logic [3:0] spi_data_bits,
   output logic [1:0] flash_chip_select
);
   import fbpll_pkg::*;

   fbp_state_t state_q;
   logic [BOOT_W-1:0] boot_q;
   logic hbe_q;
   logic [EBM_W-1:0] ebm_q;
   logic [MS_W-1:0] ms_q;
   logic fast_q;
   logic [PLL_MULTIPLIER_FIELD_W-1:0] lut_pll_multiplier_field;
   logic [PLL_MULTIPLIER_FIELD_W-1:0] pll_multiplier_field_q;
   logic [DIV_W-1:0] div_q;
   logic bypass_q;
   logic prog_q;
   logic cache_dis_q;
   logic emu_q;
   logic cont_q;
   logic [4:0] ee_q;
   logic [3:0] spi_q;
   logic [1:0] cs_q;

   function automatic logic is_direct(input logic [BOOT_W-1:0] src,
                                      input logic fast);
      // Direct external boot never runs the loader
      is_direct = (src == BOOT_DIRECT_EXT && !fast) ||
                  (src == BOOT_EXT_NOAIS && fast);
   endfunction : is_direct

   // Straps caught once at the first clock after reset release
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= FBP_IDLE;
      end else begin
         case (state_q)
            FBP_IDLE: state_q <= FBP_LATCH;
            FBP_LATCH: state_q <= FBP_APPLY;
            FBP_APPLY: state_q <= FBP_HOLD;
            FBP_HOLD: state_q <= FBP_HOLD;
            default: state_q <= FBP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         boot_q <= BOOT_EMU;
         hbe_q <= 1'b0;
         ebm_q <= '0;
         ms_q <= '0;
         fast_q <= 1'b0;
      end else if (state_q == FBP_IDLE) begin
         boot_q <= boot_source_strap;
         hbe_q <= host_bus_enable_strap;
         ebm_q <= ext_bus_mode_strap;
         ms_q <= multiplier_select_strap;
         fast_q <= fast_start_strap;
      end
   end

   fbpll_mult_lut fbpll_mult_lut_i (
      .boot_source(boot_q),
      .host_bus_enable_strap(hbe_q),
      .ext_bus_mode_strap(ebm_q),
      .multiplier_select_strap(ms_q),
      .pll_multiplier_field(lut_pll_multiplier_field)
   );

   // PLL settings applied once, then frozen
   always_ff @(posedge clock) begin
      if (srst) begin
         pll_multiplier_field_q <= PLL_MULTIPLIER_FIELD_RESET;
         div_q <= DIV_BY1;
         bypass_q <= 1'b1;
         prog_q <= 1'b0;
      end else if (state_q == FBP_LATCH) begin
         if (fast_q && boot_q != BOOT_EMU) begin
            pll_multiplier_field_q <= lut_pll_multiplier_field;
            div_q <= DIV_BY2;
            bypass_q <= 1'b0;
            prog_q <= 1'b1;
         end else begin
            pll_multiplier_field_q <= PLL_MULTIPLIER_FIELD_RESET;
            div_q <= DIV_BY1;
            bypass_q <= 1'b1;
            prog_q <= 1'b0;
         end
      end else begin
         prog_q <= 1'b0;
      end
   end

   // Boot resumes only after PLL settings are in place
   always_ff @(posedge clock) begin
      if (srst) begin
         cont_q <= 1'b0;
         emu_q <= 1'b0;
         cache_dis_q <= 1'b0;
      end else if (state_q == FBP_APPLY) begin
         cont_q <= boot_q != BOOT_EMU;
         emu_q <= boot_q == BOOT_EMU;
         cache_dis_q <= !is_direct(boot_q, fast_q);
      end
   end

   // Peripheral limits of the loader, constant by design
   always_ff @(posedge clock) begin
      if (srst) begin
         ee_q <= EEPROM_ADDR_BITS_V;
         spi_q <= SPI_DATA_BITS_V;
         cs_q <= FLASH_CS_V;
      end else begin
         ee_q <= EEPROM_ADDR_BITS_V;
         spi_q <= SPI_DATA_BITS_V;
         cs_q <= FLASH_CS_V;
      end
   end

   assign boot_config_latch = boot_q;
   assign pll_multiplier_field = pll_multiplier_field_q;
   assign core_clock_divider = div_q;
   assign pll_bypass = bypass_q;
   assign pll_program = prog_q;
   assign cache_disable = cache_dis_q;
   assign emulation_idle = emu_q;
   assign boot_continue = cont_q;
   assign eeprom_addr_bits = ee_q;
   assign spi_data_bits = spi_q;
   assign flash_chip_select = cs_q;
endmodule : fbpll_select

// >>> hdl/fbpll_pkg.sv
package fbpll_pkg;
   localparam int BOOT_W = 4;
   localparam int EBM_W = 3;
   localparam int MS_W = 3;
   localparam int PLL_MULTIPLIER_FIELD_W = 5;
   localparam int DIV_W = 5;
   // Boot source codes
   localparam logic [BOOT_W-1:0] BOOT_EMU = 4'h0;
   localparam logic [BOOT_W-1:0] BOOT_SRC_1 = 4'h1;
   localparam logic [BOOT_W-1:0] BOOT_SRC_3 = 4'h3;
   localparam logic [BOOT_W-1:0] BOOT_DIRECT_EXT = 4'h4;
   localparam logic [BOOT_W-1:0] BOOT_EXT_NOAIS = 4'h9;
   localparam logic [BOOT_W-1:0] BOOT_I2C = 4'h5;
   localparam logic [BOOT_W-1:0] BOOT_SPI16 = 4'h6;
   localparam logic [BOOT_W-1:0] BOOT_NAND = 4'h7;
   localparam logic [BOOT_W-1:0] BOOT_SPI24 = 4'hF;
   localparam logic [EBM_W-1:0] EBM_FIXED = 3'h1;
   // Multiplier field values
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X27 = 5'h1A;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X15 = 5'h0E;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X20 = 5'h13;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X16 = 5'h0F;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X18 = 5'h11;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X22 = 5'h15;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X25 = 5'h18;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_X30 = 5'h1D;
   localparam logic [PLL_MULTIPLIER_FIELD_W-1:0] PLL_MULTIPLIER_FIELD_RESET = 5'h00;
   localparam logic [DIV_W-1:0] DIV_BY2 = 5'h01;
   localparam logic [DIV_W-1:0] DIV_BY1 = 5'h00;
   localparam int EEPROM_ADDR_BITS = 16;
   localparam int SPI_DATA_BITS = 8;
   localparam int FLASH_CS_INDEX = 2;
   localparam logic [4:0] EEPROM_ADDR_BITS_V = 5'h10;
   localparam logic [3:0] SPI_DATA_BITS_V = 4'h8;
   localparam logic [1:0] FLASH_CS_V = 2'h2;
   typedef enum logic [1:0] {
      FBP_IDLE,
      FBP_LATCH,
      FBP_APPLY,
      FBP_HOLD
   } fbp_state_t;
endpackage : fbpll_pkg

// >>> hdl/fbpll_mult_lut.sv
`timescale 1ns/1ns
module fbpll_mult_lut
   import fbpll_pkg::*;
(
   input wire logic [fbpll_pkg::BOOT_W-1:0] boot_source,
   input wire logic host_bus_enable_strap,
   input wire logic [fbpll_pkg::EBM_W-1:0] ext_bus_mode_strap,
   input wire logic [fbpll_pkg::MS_W-1:0] multiplier_select_strap,
   output logic [fbpll_pkg::PLL_MULTIPLIER_FIELD_W-1:0] pll_multiplier_field
);
   // No range check: the board owns legal choices
   always_comb begin
      if (ext_bus_mode_strap == EBM_FIXED) begin
         if (boot_source == BOOT_SRC_1 && !host_bus_enable_strap) begin
            pll_multiplier_field = PLL_MULTIPLIER_FIELD_X27;
         end else if (boot_source == BOOT_SRC_3 &&
                      !host_bus_enable_strap) begin
            pll_multiplier_field = PLL_MULTIPLIER_FIELD_X15;
         end else begin
            pll_multiplier_field = PLL_MULTIPLIER_FIELD_X20;
         end
      end else begin
         case (multiplier_select_strap)
            3'h0: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X20;
            3'h1: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X15;
            3'h2: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X16;
            3'h3: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X18;
            3'h4: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X22;
            3'h5: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X25;
            3'h6: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X27;
            default: pll_multiplier_field = PLL_MULTIPLIER_FIELD_X30;
         endcase
      end
   end
endmodule : fbpll_mult_lut

// >>> tb/fbpll_select_chk.sv
`timescale 1ns/1ns
module fbpll_select_chk
   import fbpll_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [fbpll_pkg::BOOT_W-1:0] boot_config_latch,
   input wire logic [fbpll_pkg::PLL_MULTIPLIER_FIELD_W-1:0] pll_multiplier_field,
   input wire logic [fbpll_pkg::DIV_W-1:0] core_clock_divider,
   input wire logic pll_bypass,
   input wire logic pll_program,
   input wire logic cache_disable,
   input wire logic emulation_idle,
   input wire logic boot_continue,
   input wire logic [4:0] eeprom_addr_bits,
   input wire logic [3:0] spi_data_bits
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   prog_once_a: assert property (pll_program |=>
      (!pll_program) [*4]) else $error("program pulse repeated");
   prog_div_a: assert property (pll_program |-> !pll_bypass
      && core_clock_divider == 5'h01) else $error("fast divider wrong");
   bypass_div_a: assert property (pll_bypass |->
      core_clock_divider == 5'h00 && pll_multiplier_field == 5'h00)
      else $error("bypass fields wrong");
   emu_idle_a: assert property (emulation_idle |-> pll_bypass
      && !boot_continue && boot_config_latch == 4'h0)
      else $error("emulation state wrong");
   prog_first_a: assert property (pll_program |=> boot_continue)
      else $error("boot did not follow program");
   fields_hold_a: assert property (boot_continue |=>
      $stable(pll_multiplier_field) && $stable(pll_bypass))
      else $error("fields moved after boot");
   cache_keep_a: assert property (boot_continue &&
      !cache_disable |-> boot_config_latch inside {4'h4, 4'h9})
      else $error("cache left on wrongly");
   eeprom_w_a: assert property (eeprom_addr_bits == 5'h10)
      else $error("eeprom address width wrong");
   spi_w_a: assert property (spi_data_bits == 4'h8)
      else $error("spi data width wrong");
endmodule : fbpll_select_chk

// >>> tb/fbpll_strap_board.sv
`timescale 1ns/1ns
module fbpll_strap_board
   import fbpll_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic [11:0] plan,
   output logic [11:0] pins
);
   logic [1:0] age_q;
   always_ff @(posedge clock) begin
      if (srst) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
   end
   // Pins wander after the sample edge, so a live-pin design is caught
   assign pins = (age_q == 2'h0) ? plan : ~plan;
endmodule : fbpll_strap_board

// >>> tb/tb_fast_boot_pll_multiplier_select.sv
`timescale 1ns/1ns
module tb_fast_boot_pll_multiplier_select;
   import fbpll_pkg::*;
   logic clock = 0;
   logic srst = 1;
   logic [11:0] plan = 12'h000;
   logic [11:0] pins;
   logic [3:0] latch;
   logic [4:0] fld, div, ea;
   logic [3:0] sd;
   logic [1:0] cs;
   logic byp, prog, cd, idle, cont, p;
   logic [14:0] exp_q[$];
   logic [14:0] ev;
   int n_mismatch = 0;
   int check_count = 0;
   integer seed = 32'h4456325B;
   logic [31:0] r;
   logic [11:0] nxt;
   logic [4:0] tab [8] = '{PLL_MULTIPLIER_FIELD_X20, PLL_MULTIPLIER_FIELD_X15, PLL_MULTIPLIER_FIELD_X16, PLL_MULTIPLIER_FIELD_X18,
      PLL_MULTIPLIER_FIELD_X22, PLL_MULTIPLIER_FIELD_X25, PLL_MULTIPLIER_FIELD_X27, PLL_MULTIPLIER_FIELD_X30};
   // Directed straps first, so the rare table corners are always reached
   logic [11:0] dir [6] = '{12'h111, 12'h311, 12'h191, 12'h02F, 12'h400,
      12'h927};
   fbpll_strap_board fbpll_strap_board_i(.clock, .srst, .plan, .pins);
   fbpll_select fbpll_select_i(.clock, .srst,
      .boot_source_strap(pins[11:8]), .host_bus_enable_strap(pins[7]),
      .ext_bus_mode_strap(pins[6:4]), .multiplier_select_strap(pins[3:1]),
      .fast_start_strap(pins[0]), .boot_config_latch(latch),
      .pll_multiplier_field(fld), .core_clock_divider(div),
      .pll_bypass(byp), .pll_program(prog), .cache_disable(cd),
      .emulation_idle(idle), .boot_continue(cont), .eeprom_addr_bits(ea),
      .spi_data_bits(sd), .flash_chip_select(cs));
   initial begin
      forever #50 clock = ~clock;
   end
   function automatic logic [14:0] expv(input logic [11:0] q);
      logic run;
      logic [4:0] f;
      run = q[0] && q[11:8] != BOOT_EMU;
      f = 5'h00;
      if (run) f = (q[6:4] == EBM_FIXED) ? PLL_MULTIPLIER_FIELD_X20 : tab[q[3:1]];
      if (run && q[6:4] == EBM_FIXED && !q[7] && q[11:8] == 4'h1) f = 5'h1A;
      if (run && q[6:4] == EBM_FIXED && !q[7] && q[11:8] == 4'h3) f = 5'h0E;
      return {f, run ? DIV_BY2 : DIV_BY1, !run, run,
         !((!q[0] && q[11:8] == 4'h4) || (q[0] && q[11:8] == 4'h9)),
         q[11:8] == 4'h0, q[11:8] != 4'h0};
   endfunction : expv
   task automatic chk(input string nm, input logic [14:0] e, g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   initial begin
      forever begin
         @(negedge srst);
         repeat (2) @(posedge clock);
         #1 p = prog;
         @(posedge clock);
         #1;
         ev = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7FFF;
         chk("pll_multiplier_field", {10'h0, ev[14:10]}, {10'h0, fld});
         chk("div", {10'h0, ev[9:5]}, {10'h0, div});
         chk("flags", {10'h0, ev[4:0]},
            {10'h0, byp, p, cd, idle, cont});
         chk("latch", {11'h0, plan[11:8]}, {11'h0, latch});
         chk("limits", {4'h0, EEPROM_ADDR_BITS_V, SPI_DATA_BITS_V,
            FLASH_CS_V}, {4'h0, ea, sd, cs});
      end
   end
   initial begin
      @(posedge clock);
      for (int i = 0; i < 150; i++) begin
         #1 r = $random(seed);
         // All choices give x15..x30, inside the PLL range
         nxt = {r[3:0], r[4], r[9] ? EBM_FIXED : r[12:10], r[7:5], r[8]};
         if (i < 6) begin
            nxt = dir[i];
         end
         // Board never straps a host bus boot from boot source 1 or 2 without fast start
         if (nxt[7] && nxt[11:8] inside {4'h1, 4'h2}) begin
            nxt[0] = 1'b1;
         end
         plan = nxt;
         srst = 1'b1;
         repeat (4) @(posedge clock);
         #1 srst = 1'b0;
         exp_q.push_back(expv(plan));
         repeat (5) @(posedge clock);
      end
      report_and_stop();
   end
endmodule : tb_fast_boot_pll_multiplier_select
bind fbpll_select fbpll_select_chk fbpll_select_chk_i(.clock, .srst,
   .boot_config_latch,
   .pll_multiplier_field, .core_clock_divider, .pll_bypass, .pll_program,
   .cache_disable, .emulation_idle, .boot_continue, .eeprom_addr_bits,
   .spi_data_bits);
